// >>> core/dma_scan_top.sv
// dma address generation for two general channels and the adc scan channel, apb slave
//
// How it works
// RULE1 - writing a channel start low byte loads the low eight bits of its address, the high nibble register gives the rest.
// RULE2 - each finished transfer advances the current address by one in byte mode or two in word mode.
// RULE3 - reading the start low byte returns the low byte of the next transfer address.
// RULE4 - end high nibble and end low byte form the 12-bit end address of the block.
// RULE5 - scan destination is base bits 7 to 1, then the 4-bit input number, then a zero.
// RULE6 - the five low scan address bits are twice the input number.
// RULE7 - a 10-bit result goes out as two bytes, upper byte at the even address, rest at the odd one.
// RULE8 - software writes zero to scan base bit 0 and scan control bits 5 and 4.
// RULE9 - clearing scan enable stops the scan channel and zeroes its input number; setting it enables.
// RULE10 - with scan interrupt enable set an interrupt follows storing the last selected input, never otherwise.
// RULE11 - the last-input field selects inputs 0 up to its value, values 12 to 15 reserved.
// RULE12 - a general channel peripheral address is hex F above its 8-bit peripheral register.
// RULE13 - word select picks one byte per request when clear, two when set.
// RULE14 - reading the status register clears all three interrupt indicators.
// RULE15 - a channel completes once the transfer at the end address finishes.
// RULE16 - enabled scan steps the input from zero to the last input per result, then wraps to zero.
`timescale 1ns/1ps
`default_nettype none
module dma_scan_top
  import dma_scan_pkg::*;
(
  input  wire logic                     REF_CLK_I,
  input  wire logic                     SRST_I,
  input  wire logic                     PSEL_I,
  input  wire logic                     PENABLE_I,
  input  wire logic                     PWRITE_I,
  input  wire logic [31:0]              PADDR_I,
  input  wire logic [31:0]              PWDATA_I,
  input  wire logic [3:0]               PSTRB_I,
  output logic      [31:0]              PRDATA_O,
  output logic                          PREADY_O,
  output logic                          PSLVERR_O,
  input  wire logic [1:0]               XFER_DONE_I,
  input  wire logic                     ADC_RESULT_VALID_I,
  input  wire logic [9:0]               ADC_RESULT_I,
  output logic                          ADC_RESULT_READY_O,
  output var  dma_scan_pkg::rf_write_t  RF_WRITE_O,
  output logic [11:0]                   CH0_ADDR_O,
  output logic [11:0]                   CH0_IO_ADDR_O,
  output logic                          CH0_WORD_O,
  output logic [11:0]                   CH1_ADDR_O,
  output logic [11:0]                   CH1_IO_ADDR_O,
  output logic                          CH1_WORD_O,
  output logic [3:0]                    SCAN_INPUT_O,
  output logic                          SCAN_ACTIVE_O,
  output logic                          DMA_IRQ_O
);
  import dma_scan_pkg::*;

  typedef enum {SC_IDLE, SC_WAIT, SC_HIGH, SC_LOW} scan_state_t;

  function automatic logic [11:0] reg_of(input logic [31:0] byte_addr);
    reg_of = byte_addr[13:2];
  endfunction

  logic [11:0]  reg_addr;
  logic         acc;
  logic         wr;
  logic         rd;
  logic         mapped;
  logic [7:0]   rdata;
  logic [7:0]   ch_rdata [2];
  logic [1:0]   ch_hit;
  logic [1:0]   ch_done;
  chan_view_t   ch_view [2];
  logic [7:0]   scan_base_r;
  logic [7:0]   scan_ctl_r;
  logic [3:0]   scan_input_r;
  logic [9:0]   result_r;
  logic [2:0]   irq_ind_r;
  logic         scan_done;
  logic [11:0]  scan_addr;
  scan_state_t  scan_state_r;
  scan_state_t  scan_state_nxt;

  // apb: one wait-free access phase, byte register in the low lane
  assign reg_addr = reg_of(PADDR_I);
  assign acc      = PSEL_I && PENABLE_I && PREADY_O;
  // an address with upper bits set answers with an error and must not touch any register or indicator
  assign wr       = acc && PWRITE_I && PSTRB_I[0] && PADDR_I[31:14] == 18'h00000;
  assign rd       = acc && !PWRITE_I && PADDR_I[31:14] == 18'h00000;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      dma_chan_addr #(
        .BASE (OFF_CH0_CTL + (g == 0 ? 12'h000 : CH1_STRIDE))
      ) u_chan (
        .clk_i        (REF_CLK_I),
        .srst_i       (SRST_I),
        .wr_i         (wr),
        .addr_i       (reg_addr),
        .wdata_i      (PWDATA_I[7:0]),
        .xfer_done_i  (XFER_DONE_I[g]),
        .view_o       (ch_view[g]),
        .block_done_o (ch_done[g]),
        .rdata_o      (ch_rdata[g]),
        .hit_o        (ch_hit[g])
      );
    end
  endgenerate

  assign mapped = (|ch_hit) || reg_addr == OFF_SCAN_BASE || reg_addr == OFF_SCAN_CTL || reg_addr == OFF_STATUS
                  || PADDR_I[31:14] != 18'h00000;

  always_comb begin
    rdata = 8'h00;
    if (ch_hit[0]) rdata = ch_rdata[0];
    else if (ch_hit[1]) rdata = ch_rdata[1];
    else if (reg_addr == OFF_SCAN_BASE) rdata = scan_base_r;
    else if (reg_addr == OFF_SCAN_CTL) rdata = scan_ctl_r;
    else if (reg_addr == OFF_STATUS) rdata = {scan_input_r, 1'b0, irq_ind_r};
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h00000000;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= PSEL_I && !PENABLE_I;
      PSLVERR_O <= PSEL_I && !PENABLE_I && !(mapped && PADDR_I[31:14] == 18'h00000);
      if (PSEL_I && !PENABLE_I && !PWRITE_I) PRDATA_O <= {24'h000000, rdata};
    end
  end

  // reserved bits are stored as written; software keeps them zero
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      scan_base_r <= SCAN_BASE_RST;
      scan_ctl_r  <= SCAN_CTL_RST;
    end else if (wr) begin
      if (reg_addr == OFF_SCAN_BASE) scan_base_r <= PWDATA_I[7:0]; // RULE8
      if (reg_addr == OFF_SCAN_CTL) scan_ctl_r <= PWDATA_I[7:0]; // RULE8 RULE11
    end
  end

  assign scan_addr = {scan_base_r[7:1], scan_input_r, 1'b0}; // RULE5 RULE6
  assign scan_done = scan_state_r == SC_LOW && scan_input_r == scan_ctl_r[3:0];

  always_comb begin
    scan_state_nxt = scan_state_r;
    case (scan_state_r)
      SC_IDLE: if (scan_ctl_r[SCAN_EN_BIT]) scan_state_nxt = SC_WAIT; // RULE9
      SC_WAIT: if (ADC_RESULT_VALID_I) scan_state_nxt = SC_HIGH;
      SC_HIGH: scan_state_nxt = SC_LOW;
      SC_LOW:  scan_state_nxt = SC_WAIT;
      default: scan_state_nxt = SC_IDLE;
    endcase
    if (!scan_ctl_r[SCAN_EN_BIT]) scan_state_nxt = SC_IDLE; // RULE9
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) scan_state_r <= SC_IDLE;
    else scan_state_r <= scan_state_nxt;
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) result_r <= 10'h000;
    else if (scan_state_r == SC_WAIT && ADC_RESULT_VALID_I) result_r <= ADC_RESULT_I;
  end

  // a reserved last-input value wraps at that value, after stepping through inputs 12 and up
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I || !scan_ctl_r[SCAN_EN_BIT]) begin
      scan_input_r <= 4'h0; // RULE9
    end else if (scan_state_r == SC_LOW) begin
      scan_input_r <= scan_done ? 4'h0 : scan_input_r + 4'h1; // RULE16 RULE11
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      RF_WRITE_O <= '0;
    end else begin
      RF_WRITE_O.valid <= scan_state_r == SC_HIGH || scan_state_r == SC_LOW;
      if (scan_state_r == SC_HIGH) begin
        RF_WRITE_O.addr <= scan_addr; // RULE7
        RF_WRITE_O.data <= result_r[9:2]; // RULE7
      end else if (scan_state_r == SC_LOW) begin
        RF_WRITE_O.addr <= scan_addr | 12'h001; // RULE7
        RF_WRITE_O.data <= {result_r[1:0], 6'h00}; // RULE7
      end
    end
  end

  // a new completion in the read cycle survives the clear
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      irq_ind_r <= 3'h0;
    end else begin
      irq_ind_r <= ((rd && reg_addr == OFF_STATUS) ? 3'h0 : irq_ind_r) // RULE14
                   | {scan_done && scan_ctl_r[SCAN_IE_BIT], ch_done}; // RULE10 RULE15
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      DMA_IRQ_O          <= 1'b0;
      ADC_RESULT_READY_O <= 1'b0;
      SCAN_INPUT_O       <= 4'h0;
      SCAN_ACTIVE_O      <= 1'b0;
      CH0_ADDR_O         <= 12'h000;
      CH0_IO_ADDR_O      <= 12'h000;
      CH0_WORD_O         <= 1'b0;
      CH1_ADDR_O         <= 12'h000;
      CH1_IO_ADDR_O      <= 12'h000;
      CH1_WORD_O         <= 1'b0;
    end else begin
      DMA_IRQ_O          <= |irq_ind_r;
      ADC_RESULT_READY_O <= scan_state_nxt == SC_WAIT;
      SCAN_INPUT_O       <= scan_input_r;
      SCAN_ACTIVE_O      <= scan_ctl_r[SCAN_EN_BIT];
      CH0_ADDR_O         <= ch_view[0].addr;
      CH0_IO_ADDR_O      <= ch_view[0].io_addr; // RULE12
      CH0_WORD_O         <= ch_view[0].word; // RULE13
      CH1_ADDR_O         <= ch_view[1].addr;
      CH1_IO_ADDR_O      <= ch_view[1].io_addr;
      CH1_WORD_O         <= ch_view[1].word;
    end
  end

  chk_scan_addr: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // RULE6
    scan_state_r == SC_HIGH |=> RF_WRITE_O.addr[4:0] == {$past(scan_input_r), 1'b0})
    else $error("scan low address bits not twice the input");
  chk_pair_order: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // RULE7
    scan_state_r == SC_HIGH |=> RF_WRITE_O.valid ##1 RF_WRITE_O.valid && RF_WRITE_O.addr[0])
    else $error("byte pair not written even then odd");
  chk_disable_zero: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // RULE9
    !scan_ctl_r[SCAN_EN_BIT] |=> scan_input_r == 4'h0 && scan_state_r == SC_IDLE)
    else $error("scan not stopped when disabled");
  chk_scan_irq: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // RULE10
    scan_done && !scan_ctl_r[SCAN_IE_BIT] && !irq_ind_r[2] |=> !irq_ind_r[2])
    else $error("scan interrupt raised while disabled");
  chk_wrap_zero: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // RULE16
    scan_done && scan_ctl_r[SCAN_EN_BIT] |=> scan_input_r == 4'h0)
    else $error("scan input did not wrap");
  chk_status_clear: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // RULE14
    rd && reg_addr == OFF_STATUS && !scan_done && ch_done == 2'b00 |=> irq_ind_r == 3'h0)
    else $error("status read did not clear indicators");
  chk_rf_base: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // RULE5
    scan_state_r == SC_HIGH |=> RF_WRITE_O.addr[11:5] == $past(scan_base_r[7:1]))
    else $error("scan address top bits not from the base register");
  chk_high_byte: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // RULE7
    scan_state_r == SC_HIGH |=> RF_WRITE_O.data == $past(result_r[9:2]))
    else $error("even byte does not hold the upper result bits");
  chk_low_byte: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // RULE7
    scan_state_r == SC_LOW |=> RF_WRITE_O.data == {$past(result_r[1:0]), 6'h00})
    else $error("odd byte does not hold the lower result bits");
  chk_quiet_wait: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // RULE7
    scan_state_r == SC_WAIT |=> !RF_WRITE_O.valid)
    else $error("register file write outside a result pair");
  chk_take_result: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // RULE7
    scan_state_r == SC_WAIT && ADC_RESULT_VALID_I |=> result_r == $past(ADC_RESULT_I))
    else $error("offered result not captured");
  chk_ready_wait: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // RULE16
    ADC_RESULT_READY_O == (scan_state_r == SC_WAIT))
    else $error("result ready does not follow the waiting state");
  chk_input_step: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // RULE16
    scan_state_r == SC_LOW && !scan_done |=> scan_input_r == $past(scan_input_r) + 4'h1)
    else $error("scan input did not step to the next input");
  chk_irq_follow: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // RULE10
    DMA_IRQ_O == $past(|irq_ind_r))
    else $error("interrupt output does not follow the indicators");
  // first cycle after reset still shows the cleared output flops
  chk_io_page: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // RULE12
    !$past(SRST_I) |-> CH0_IO_ADDR_O[11:8] == 4'hF && CH1_IO_ADDR_O[11:8] == 4'hF)
    else $error("peripheral address left the top page");
  chk_ready_pulse: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    PREADY_O == $past(PSEL_I && !PENABLE_I))
    else $error("ready is not one cycle after the setup cycle");
  chk_err_ready: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
    PSLVERR_O |-> PREADY_O)
    else $error("error response without ready");
  cov_word_done: cover property (@(posedge REF_CLK_I) ch_done[1] && ch_view[1].word);
  cov_scan_stop: cover property (@(posedge REF_CLK_I) scan_state_r != SC_IDLE && !scan_ctl_r[SCAN_EN_BIT]);
  cov_scan_wrap: cover property (@(posedge REF_CLK_I) scan_done);
  cov_chan_done: cover property (@(posedge REF_CLK_I) ch_done[0]);
  cov_status_rd: cover property (@(posedge REF_CLK_I) rd && reg_addr == OFF_STATUS && irq_ind_r != 3'h0);
endmodule
`default_nettype wire

// >>> core/dma_scan_pkg.sv
// shared constants and carrier types for the dma address and adc scan block
package dma_scan_pkg;
  localparam logic [11:0] OFF_CH0_CTL   = 12'hFB0;
  localparam logic [11:0] OFF_CH0_IO    = 12'hFB1;
  localparam logic [11:0] OFF_CH0_HI    = 12'hFB2;
  localparam logic [11:0] OFF_CH0_START = 12'hFB3;
  localparam logic [11:0] OFF_CH0_END   = 12'hFB4;
  localparam logic [11:0] OFF_CH1_CTL   = 12'hFB8;
  localparam logic [11:0] OFF_CH1_IO    = 12'hFB9;
  localparam logic [11:0] OFF_CH1_HI    = 12'hFBA;
  localparam logic [11:0] OFF_CH1_START = 12'hFBB;
  localparam logic [11:0] OFF_CH1_END   = 12'hFBC;
  localparam logic [11:0] OFF_SCAN_BASE = 12'hFBD;
  localparam logic [11:0] OFF_SCAN_CTL  = 12'hFBE;
  localparam logic [11:0] OFF_STATUS    = 12'hFBF;
  localparam logic [11:0] CH1_STRIDE    = 12'h008;
  localparam logic [11:0] IO_PAGE_BASE  = 12'hF00;
  localparam int          CTL_WORD_SELECT_BIT  = 3;
  localparam int          CTL_EN_BIT    = 7;
  localparam int          SCAN_EN_BIT   = 7;
  localparam int          SCAN_IE_BIT   = 6;
  localparam logic [7:0]  CTL_RST       = 8'h00;
  localparam logic [7:0]  SCAN_CTL_RST  = 8'h00;
  localparam logic [7:0]  SCAN_BASE_RST = 8'h00;
  localparam logic [7:0]  SCAN_RSVD_MSK = 8'h30;
  localparam logic [3:0]  SCAN_LAST_MAX = 4'hB;

  typedef struct packed {
    logic [11:0] addr;
    logic [11:0] io_addr;
    logic        word;
    logic        active;
  } chan_view_t;

  typedef struct packed {
    logic        valid;
    logic [11:0] addr;
    logic [7:0]  data;
  } rf_write_t;
endpackage

// >>> core/dma_chan_addr.sv
// one general dma channel: control, peripheral, start/current and end address registers
`timescale 1ns/1ps
`default_nettype none
module dma_chan_addr
  import dma_scan_pkg::*;
#(
  parameter logic [11:0] BASE = 12'hFB0
) (
  input  wire logic                     clk_i,
  input  wire logic                     srst_i,
  input  wire logic                     wr_i,
  input  wire logic [11:0]              addr_i,
  input  wire logic [7:0]               wdata_i,
  input  wire logic                     xfer_done_i,
  output var  dma_scan_pkg::chan_view_t view_o,
  output logic                          block_done_o,
  output logic [7:0]                    rdata_o,
  output logic                          hit_o
);
  logic [7:0]  ctl_r;
  logic [7:0]  io_r;
  logic [3:0]  end_hi_r;
  logic [11:0] cur_r;
  logic [7:0]  end_lo_r;
  logic [11:0] end_addr;
  logic [11:0] step;

  assign end_addr = {end_hi_r, end_lo_r}; // RULE4
  assign step = ctl_r[CTL_WORD_SELECT_BIT] ? 12'h002 : 12'h001; // RULE2 RULE13
  assign block_done_o = xfer_done_i && ctl_r[CTL_EN_BIT] && (cur_r == end_addr); // RULE15
  assign view_o = '{addr: cur_r, io_addr: IO_PAGE_BASE | {4'h0, io_r}, // RULE12
                    word: ctl_r[CTL_WORD_SELECT_BIT], active: ctl_r[CTL_EN_BIT]};
  assign hit_o = (addr_i >= BASE) && (addr_i <= BASE + 12'h004);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctl_r    <= CTL_RST;
      io_r     <= 8'h00;
      end_hi_r <= 4'h0;
      end_lo_r <= 8'h00;
    end else if (wr_i) begin
      if (addr_i == BASE) ctl_r <= wdata_i;
      if (addr_i == BASE + 12'h001) io_r <= wdata_i;
      if (addr_i == BASE + 12'h002) end_hi_r <= wdata_i[7:4];
      if (addr_i == BASE + 12'h004) end_lo_r <= wdata_i;
    end
  end

  // software write beats a same-cycle advance so a fresh start is never skipped
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cur_r <= 12'h000;
    end else if (wr_i && addr_i == BASE + 12'h003) begin
      cur_r <= {cur_r[11:8], wdata_i}; // RULE1
    end else if (wr_i && addr_i == BASE + 12'h002) begin
      cur_r <= {wdata_i[3:0], cur_r[7:0]}; // RULE1
    end else if (xfer_done_i && ctl_r[CTL_EN_BIT]) begin
      cur_r <= cur_r + step; // RULE2
    end
  end

  always_comb begin
    rdata_o = 8'h00;
    case (addr_i - BASE)
      12'h000: rdata_o = ctl_r;
      12'h001: rdata_o = io_r;
      12'h002: rdata_o = {end_hi_r, cur_r[11:8]};
      12'h003: rdata_o = cur_r[7:0]; // RULE3
      12'h004: rdata_o = end_lo_r;
      default: rdata_o = 8'h00;
    endcase
  end

  chk_advance_step: assert property (@(posedge clk_i) disable iff (srst_i) // RULE2
    xfer_done_i && ctl_r[CTL_EN_BIT] && !wr_i |=> cur_r == $past(cur_r) + $past(step))
    else $error("current address did not advance by the step");
  chk_start_load: assert property (@(posedge clk_i) disable iff (srst_i) // RULE1
    wr_i && addr_i == BASE + 12'h003 |=> cur_r[7:0] == $past(wdata_i))
    else $error("start low byte not loaded");
  chk_block_end: assert property (@(posedge clk_i) disable iff (srst_i) // RULE15
    block_done_o |-> cur_r == {end_hi_r, end_lo_r})
    else $error("block end flagged away from end address");
endmodule
`default_nettype wire

// >>> tb/adc_model.sv
// adc source partner: presents results on request, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module adc_model (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       ready_i,
  input  wire logic [7:0] want_i,
  output logic            valid_o,
  output logic [9:0]      result_o
);
  logic [7:0]  sent_r;
  logic [1:0]  dly_r;
  logic [15:0] lf_r;
  // idle data is the inverse of the last result so a stale capture shows
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      valid_o  <= 1'b0;
      result_o <= 10'h000;
      sent_r   <= 8'h00;
      dly_r    <= 2'h0;
      lf_r     <= 16'hACE1;
    end else begin
      lf_r <= {lf_r[14:0], lf_r[15] ^ lf_r[13] ^ lf_r[12] ^ lf_r[10]};
      if (valid_o && ready_i) begin
        valid_o  <= 1'b0;
        result_o <= ~result_o;
        sent_r   <= sent_r + 8'h01;
        dly_r    <= lf_r[1:0];
      end else if (!valid_o && sent_r != want_i) begin
        if (dly_r != 2'h0) begin
          dly_r <= dly_r - 2'h1;
        end else begin
          valid_o  <= 1'b1;
          result_o <= lf_r[9:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the dma address and adc scan block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin bad_count++; \
  $display("FAIL %s exp %0h got %0h", nm, ex, gt); end end
module tb_top;
  import dma_scan_pkg::*;
  logic        clk, rst, psel, pen, pwr, hung, ph, err;
  logic [31:0] paddr, pwdata, seed;
  logic [3:0]  pstrb, last, exp_in;
  logic [1:0]  xd;
  logic [7:0]  want, base, rd;
  logic [9:0]  res_q[$];
  int          bad_count, n_checks, rf_n;
  wire  [31:0] prdata;
  wire         pready, pslverr, aval, ardy, irq, w0, w1, act;
  wire  [9:0]  ares;
  wire  [11:0] a0, io0, a1, io1;
  wire  [3:0]  sin;
  wire rf_write_t rfw;

  dma_scan_top DUT (.REF_CLK_I(clk), .SRST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .XFER_DONE_I(xd),
    .ADC_RESULT_VALID_I(aval), .ADC_RESULT_I(ares), .ADC_RESULT_READY_O(ardy),
    .RF_WRITE_O(rfw), .CH0_ADDR_O(a0), .CH0_IO_ADDR_O(io0), .CH0_WORD_O(w0),
    .CH1_ADDR_O(a1), .CH1_IO_ADDR_O(io1), .CH1_WORD_O(w1), .SCAN_INPUT_O(sin),
    .SCAN_ACTIVE_O(act), .DMA_IRQ_O(irq));
  adc_model P (.clk_i(clk), .srst_i(rst), .ready_i(ardy), .want_i(want),
    .valid_o(aval), .result_o(ares));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d, input logic [3:0] s);
    int k;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= {18'h0, idx, 2'b00};
    pwdata <= {24'h0, d};
    pstrb  <= w ? s : 4'h0;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd  = prdata[7:0];
    err = pslverr;
    if (k >= 20) begin
      bad_count++;
      hung = 1'b1;
    end
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic chan(input int ch);
    logic [31:0] r;
    logic [11:0] st, en, b, a;
    logic [7:0]  io;
    logic        w;
    r  = xs();
    w  = (ch == 1);
    b  = w ? CH1_STRIDE : 12'h000;
    st = r[11:0];
    io = r[19:12] & (w ? 8'hFE : 8'hFF);
    en = st + (w ? 12'h006 : 12'h003);
    apb(1'b1, OFF_CH0_CTL + b, {4'h8, w, 3'h0}, 4'hF);
    apb(1'b1, OFF_CH0_IO + b, io, 4'hF);
    apb(1'b1, OFF_CH0_HI + b, {en[11:8], st[11:8]}, 4'hF);
    apb(1'b1, OFF_CH0_START + b, st[7:0], 4'hF);
    apb(1'b1, OFF_CH0_END + b, en[7:0], 4'hF);
    apb(1'b1, OFF_CH0_START + b, ~st[7:0], 4'h0);
    repeat (2) @(posedge clk);
    `CHK("addr", st, w ? a1 : a0)
    `CHK("io", {4'hF, io}, w ? io1 : io0)
    `CHK("word", w, w ? w1 : w0)
    for (int i = 1; i <= 4; i++) begin
      @(posedge clk);
      xd[ch] <= 1'b1;
      @(posedge clk);
      xd[ch] <= 1'b0;
      repeat (2) @(posedge clk);
      a = st + 12'(i * (w ? 2 : 1));
      if (i < 4) begin
        `CHK("adv", a, w ? a1 : a0)
        apb(1'b0, OFF_CH0_START + b, 8'h00, 4'hF);
        `CHK("rdcur", a[7:0], rd)
      end
      `CHK("irq", i == 4, irq)
    end
    apb(1'b0, OFF_STATUS, 8'h00, 4'hF);
    `CHK("stat", 8'h01 << ch, rd)
    apb(1'b0, OFF_STATUS, 8'h00, 4'hF);
    `CHK("clr", 8'h00, rd)
    $display("test chan %0d done", ch);
  endtask

  task automatic scan(input logic [3:0] l, input logic ie, input int n);
    logic [31:0] r;
    int          k, tgt;
    r      = xs();
    base   = r[7:0] & 8'hFE;
    last   = l;
    exp_in = 4'h0;
    apb(1'b1, OFF_SCAN_BASE, base, 4'hF);
    apb(1'b1, OFF_SCAN_CTL, {1'b1, ie, 2'b00, l}, 4'hF);
    tgt  = rf_n + 2 * n;
    want <= want + 8'(n);
    k = 0;
    while (rf_n < tgt && k < 500) begin
      @(posedge clk);
      k++;
    end
    if (k >= 500) begin
      bad_count++;
      hung = 1'b1;
    end
    repeat (3) @(posedge clk);
    `CHK("sirq", ie && n > l, irq)
    apb(1'b0, OFF_STATUS, 8'h00, 4'hF);
    `CHK("sstat", {exp_in, 1'b0, ie && n > l, 2'b00}, rd)
    `CHK("sin", exp_in, sin)
    `CHK("son", 1'b1, act)
    apb(1'b1, OFF_SCAN_CTL, 8'h00, 4'hF);
    repeat (3) @(posedge clk);
    `CHK("soff", 5'h00, {act, sin})
    $display("test scan %0h done", l);
  endtask

  always @(posedge clk) begin
    if (aval && ardy)
      res_q.push_back(ares);
    if (rfw.valid === 1'b1) begin
      `CHK("rfa", {base[7:1], exp_in, ph}, rfw.addr)
      if (!ph) begin
        `CHK("rfd", res_q[0][9:2], rfw.data)
      end else begin
        `CHK("rfd", {res_q[0][1:0], 6'h00}, rfw.data)
        void'(res_q.pop_front());
        exp_in = (exp_in == last) ? 4'h0 : exp_in + 4'h1;
      end
      ph = ~ph;
      rf_n++;
    end
  end

  initial begin
    wait (hung === 1'b1);
    close_out();
  end

  initial begin
    {rst, psel, pen, pwr, hung, ph, err} = 7'b1000000;
    {paddr, pwdata, pstrb, xd, want, base, last, exp_in} = '0;
    {bad_count, n_checks, rf_n} = '0;
    seed = 32'd95742;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, OFF_SCAN_CTL, 8'h00, 4'hF);
    `CHK("ctlrst", 8'h00, rd)
    apb(1'b1, 12'hFB5, 8'h5A, 4'hF);
    `CHK("unmw", 1'b1, err)
    apb(1'b0, 12'hFB5, 8'h00, 4'hF);
    `CHK("unmr", 9'h100, {err, rd})
    $display("test reset done");
    for (int t = 0; t < 4; t++)
      chan(t % 2);
    scan(4'h3, 1'b1, 4);
    scan(4'hB, 1'b0, 3);
    scan(4'h0, 1'b1, 2);
    scan(4'hA, 1'b1, 11);
    scan(4'hB, 1'b1, 12);
    close_out();
  end
endmodule
`default_nettype wire
